// ---- perf_counter_pkg.sv ----
/*
 * Package for the performance event counter block: register map, field
 * positions, reset values, event and mode encodings, and carrier structs.
 * Assumes a single core clock and an AHB-Lite register bus.
 */
package perf_counter_pkg;

   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [7:0] CTRL_LO_OFFSET    = 8'h00;
   localparam logic [7:0] CTRL_HI_OFFSET    = 8'h04;
   localparam logic [7:0] IRQ_SUMMARY_OFFSET = 8'h08;
   localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h0c;

   // ***************************************************
   // Field positions within the 64-bit control register and the pending/clear word
   // ***************************************************
   localparam int CNT_A_LSB      = 48;
   localparam int CNT_B_LSB      = 32;
   localparam int SEL_A_BIT      = 31;
   localparam int KILL_USER_BIT  = 30;
   localparam int CNT_C_LSB      = 16;
   localparam int CTRL_A_LSB     = 14;
   localparam int CTRL_B_LSB     = 12;
   localparam int CTRL_C_LSB     = 10;
   localparam int KILL_FW_BIT    = 9;
   localparam int KILL_SYS_BIT   = 8;
   localparam int SEL_B_LSB      = 4;
   localparam int SEL_C_LSB      = 0;
   localparam int PEND_A_BIT     = 27;
   localparam int PEND_B_BIT     = 28;
   localparam int PEND_C_BIT     = 29;

   localparam logic [63:0] CTRL_RESET = 64'h0000_0000_0000_0000;

   // ***************************************************
   // Counter control codes and thresholds
   // ***************************************************
   typedef enum logic [1:0] {
      CTRL_OFF      = 2'b00,
      CTRL_COUNT    = 2'b01,
      CTRL_IRQ_WIDE = 2'b10,
      CTRL_IRQ_256  = 2'b11
   } ctrl_code_t;

   localparam logic [16:0] THRESH_WIDE_AB = 17'h10000;
   localparam logic [16:0] THRESH_WIDE_C  = 17'h04000;
   localparam logic [16:0] THRESH_SHORT   = 17'h00100;

   localparam logic [3:0] SEL_C_JUMP_MISPREDICT   = 4'h2;
   localparam logic [3:0] SEL_C_BRANCH_MISPREDICT = 4'h3;

   // ***************************************************
   // Processor modes
   // ***************************************************
   typedef enum logic [1:0] {
      MODE_KERNEL     = 2'b00,
      MODE_EXECUTIVE  = 2'b01,
      MODE_SUPERVISOR = 2'b10,
      MODE_USER       = 2'b11
   } cpu_mode_t;

   // ***************************************************
   // Carriers
   // ***************************************************
   typedef struct packed {
      logic       cycle;
      logic       validNoIssue;
      logic       splitIssue;
      logic       pipeDry;
      logic       replayTrap;
      logic [2:0] issueCount;
      logic       jumpRet;
      logic       condBranch;
      logic       flowChange;
      logic       intOp;
      logic       fpOp;
      logic       load;
      logic       store;
      logic       icacheIssue;
      logic       dcacheAccess;
      logic       longStall;
      logic       jumpMispredict;
      logic       branchMispredict;
      logic       icacheMiss;
      logic       itlbMiss;
      logic       dcacheLoadMiss;
      logic       dtlbMiss;
      logic       missFileMerge;
      logic       loadUseReplay;
      logic       missFileFullReplay;
      logic       barrierStall;
      logic       loadLocked;
      logic [1:0] busUnitEvent;
   } perf_events_t;

   typedef struct packed {
      logic      firmwareMode;
      cpu_mode_t mode;
   } cpu_state_t;

endpackage

// ---- perf_event_counters.sv ----
/*
 * Three performance event counters behind one 64-bit control register,
 * reached as two 32-bit words over AHB-Lite, plus pending and clear words.
 * Assumes event strobes and processor mode come from logic on the same
 * clock, valid for one cycle per event.
 */
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module perf_event_counters (
   input  wire logic                         clock,
   input  wire logic                         rst,
   input  wire logic                         hsel,
   input  wire logic [7:0]                   haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic      [31:0]                  hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   input  wire perf_counter_pkg::perf_events_t events,
   input  wire perf_counter_pkg::cpu_state_t   cpuState,
   output logic      [2:0]                   pendingIrq
);

   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic logic crossThreshold(
      input logic [1:0]  ctrl,
      input logic [16:0] nextCount,
      input logic [16:0] wide
   );
      logic hit;
      hit = 1'b0;
      if (ctrl == 2'b10)
         hit = (nextCount == wide);
      else if (ctrl == 2'b11)
         hit = (nextCount == perf_counter_pkg::THRESH_SHORT);
      return hit;
   endfunction

   // ***************************************************
   // Bus slave
   // ***************************************************
   logic [63:0] ctrl_r;
   logic [2:0]  pending_r;
   logic        wrPend_r;
   logic [7:0]  wrAddr_r;
   logic        rdValid;
   logic [31:0] rdData;

   assign rdValid = hsel && hready && htrans[1] && !hwrite;

   // Address phase captured; zero-wait data phase follows.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
      end
      else if (hready)
      begin
         wrPend_r <= hsel && htrans[1] && hwrite;
         wrAddr_r <= haddr;
      end
   end

   always_comb
   begin
      rdData = 32'h0000_0000;
      if (haddr == perf_counter_pkg::CTRL_LO_OFFSET)
         rdData = ctrl_r[31:0];
      else if (haddr == perf_counter_pkg::CTRL_HI_OFFSET)
         rdData = ctrl_r[63:32];
      else if (haddr == perf_counter_pkg::IRQ_SUMMARY_OFFSET)
         rdData = {2'b00, pending_r, 27'h0000000};
   end

   // Read data is registered at the address phase so it stands in the
   // data phase straight from a flip-flop.
   always_ff @(posedge clock)
   begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (rdValid)
         hrdata <= rdData;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   logic wrLo;
   logic wrHi;
   logic wrClr;
   assign wrLo  = wrPend_r && (wrAddr_r == perf_counter_pkg::CTRL_LO_OFFSET);
   assign wrHi  = wrPend_r && (wrAddr_r == perf_counter_pkg::CTRL_HI_OFFSET);
   assign wrClr = wrPend_r && (wrAddr_r == perf_counter_pkg::IRQ_CLEAR_OFFSET);

   // ***************************************************
   // Field views
   // ***************************************************
   logic [15:0] cntA;
   logic [15:0] cntB;
   logic [13:0] cntC;
   logic [1:0]  ctlA;
   logic [1:0]  ctlB;
   logic [1:0]  ctlC;
   logic [3:0]  selB;
   logic [3:0]  selC;
   assign cntA = ctrl_r[perf_counter_pkg::CNT_A_LSB +: 16];
   assign cntB = ctrl_r[perf_counter_pkg::CNT_B_LSB +: 16];
   assign cntC = ctrl_r[perf_counter_pkg::CNT_C_LSB +: 14];
   assign ctlA = ctrl_r[perf_counter_pkg::CTRL_A_LSB +: 2];
   assign ctlB = ctrl_r[perf_counter_pkg::CTRL_B_LSB +: 2];
   assign ctlC = ctrl_r[perf_counter_pkg::CTRL_C_LSB +: 2];
   assign selB = ctrl_r[perf_counter_pkg::SEL_B_LSB +: 4];
   assign selC = ctrl_r[perf_counter_pkg::SEL_C_LSB +: 4];

   // ***************************************************
   // Mode kill
   // ***************************************************
   logic killU;
   logic killF;
   logic killS;
   logic allowCount;
   assign killU = ctrl_r[perf_counter_pkg::KILL_USER_BIT];
   assign killF = ctrl_r[perf_counter_pkg::KILL_FW_BIT];
   assign killS = ctrl_r[perf_counter_pkg::KILL_SYS_BIT];

   // Firmware mode overrides the architectural mode, so firmware calls made
   // from user or system code are governed by the firmware kill alone.
   always_comb
   begin
      allowCount = 1'b1;
      if (cpuState.firmwareMode)
         allowCount = !killF;
      else if (cpuState.mode == perf_counter_pkg::MODE_USER)
         allowCount = !killU;
      else if (killU && killF && killS)
         allowCount = (cpuState.mode != perf_counter_pkg::MODE_KERNEL);
      else
         allowCount = !killS;
   end

   // ***************************************************
   // Event selection
   // ***************************************************
   logic evA;
   logic evB;
   logic evC;

   assign evA = ctrl_r[perf_counter_pkg::SEL_A_BIT] ?
                (events.issueCount != 3'h0) : events.cycle;

   always_comb
   begin
      evB = 1'b0;
      case (selB)
         4'h0: evB = events.validNoIssue;
         4'h1: evB = events.splitIssue;
         4'h2: evB = events.pipeDry;
         4'h3: evB = events.replayTrap;
         4'h4: evB = (events.issueCount == 3'h1);
         4'h5: evB = (events.issueCount == 3'h2);
         4'h6: evB = (events.issueCount == 3'h3);
         4'h7: evB = (events.issueCount == 3'h4);
         4'h8:
         begin
            if (selC == perf_counter_pkg::SEL_C_JUMP_MISPREDICT)
               evB = events.jumpRet;
            else if (selC == perf_counter_pkg::SEL_C_BRANCH_MISPREDICT)
               evB = events.condBranch;
            else
               evB = events.flowChange;
         end
         4'h9: evB = events.intOp;
         4'ha: evB = events.fpOp;
         4'hb: evB = events.load;
         4'hc: evB = events.store;
         4'hd: evB = events.icacheIssue;
         4'he: evB = events.dcacheAccess;
         default: evB = events.busUnitEvent[0];
      endcase
   end

   always_comb
   begin
      evC = 1'b0;
      case (selC)
         4'h0: evC = events.longStall;
         4'h2: evC = events.jumpMispredict;
         4'h3: evC = events.branchMispredict;
         4'h4: evC = events.icacheMiss;
         4'h5: evC = events.itlbMiss;
         4'h6: evC = events.dcacheLoadMiss;
         4'h7: evC = events.dtlbMiss;
         4'h8: evC = events.missFileMerge;
         4'h9: evC = events.loadUseReplay;
         4'ha: evC = events.missFileFullReplay;
         4'hc: evC = events.cycle;
         4'hd: evC = events.barrierStall;
         4'he: evC = events.loadLocked;
         4'hf: evC = events.busUnitEvent[1];
         default: evC = 1'b0;
      endcase
   end

   // ***************************************************
   // Counting
   // ***************************************************
   logic        incA;
   logic        incB;
   logic        incC;
   logic [16:0] nxtA;
   logic [16:0] nxtB;
   logic [16:0] nxtC;
   assign incA = allowCount && (ctlA != 2'b00) && evA;
   assign incB = allowCount && (ctlB != 2'b00) && evB;
   assign incC = allowCount && (ctlC != 2'b00) && evC;
   assign nxtA = {1'b0, cntA} + 17'h00001;
   assign nxtB = {1'b0, cntB} + 17'h00001;
   assign nxtC = {3'b000, cntC} + 17'h00001;

   // A bus write to a word wins over a count in the same cycle.
   always_ff @(posedge clock)
   begin
      if (rst)
         ctrl_r <= perf_counter_pkg::CTRL_RESET;
      else
      begin
         if (wrLo)
            ctrl_r[31:0] <= hwdata;
         else
         begin
            if (incC)
               ctrl_r[perf_counter_pkg::CNT_C_LSB +: 14] <= nxtC[13:0];
         end
         if (wrHi)
            ctrl_r[63:32] <= hwdata;
         else
         begin
            if (incA)
               ctrl_r[perf_counter_pkg::CNT_A_LSB +: 16] <= nxtA[15:0];
            if (incB)
               ctrl_r[perf_counter_pkg::CNT_B_LSB +: 16] <= nxtB[15:0];
         end
      end
   end

   // ***************************************************
   // Pending interrupt flags
   // ***************************************************
   logic [2:0] hit;
   logic [2:0] clr;
   assign hit[0] = incA && crossThreshold(ctlA, nxtA,
                      perf_counter_pkg::THRESH_WIDE_AB);
   assign hit[1] = incB && crossThreshold(ctlB, nxtB,
                      perf_counter_pkg::THRESH_WIDE_AB);
   assign hit[2] = incC && crossThreshold(ctlC, nxtC,
                      perf_counter_pkg::THRESH_WIDE_C);
   assign clr = wrClr ? hwdata[perf_counter_pkg::PEND_A_BIT +: 3] : 3'b000;

   // Set wins over clear so an event in the clearing cycle is not lost.
   always_ff @(posedge clock)
   begin
      if (rst)
         pending_r <= 3'b000;
      else
         pending_r <= (pending_r & ~clr) | hit;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         pendingIrq <= 3'b000;
      else
         pendingIrq <= (pending_r & ~clr) | hit;
   end

   // ***************************************************
   // Checks
   // ***************************************************
   property p_count_a;
      @(posedge clock) disable iff (rst)
      (incA && !wrHi) |=> (cntA == $past(nxtA[15:0]));
   endproperty
   a_count_a: assert property (p_count_a) else $error("count a lost");

   property p_off_holds;
      @(posedge clock) disable iff (rst)
      (ctlB == 2'b00 && !wrHi) |=> (cntB == $past(cntB));
   endproperty
   a_off_holds: assert property (p_off_holds) else $error("b moved");

   property p_c_thresh;
      @(posedge clock) disable iff (rst)
      (incC && ctlC == 2'b10 && cntC == 14'h3fff) |=> pending_r[2];
   endproperty
   a_c_thresh: assert property (p_c_thresh) else $error("c irq lost");

   property p_kill_user;
      @(posedge clock) disable iff (rst)
      (killU && !cpuState.firmwareMode &&
       cpuState.mode == perf_counter_pkg::MODE_USER) |-> !incA;
   endproperty
   a_kill_user: assert property (p_kill_user) else $error("user ran");

   property p_kill_fw;
      @(posedge clock) disable iff (rst)
      (killF && cpuState.firmwareMode) |-> !(incA || incB || incC);
   endproperty
   a_kill_fw: assert property (p_kill_fw) else $error("fw counted");

   property p_all_kill;
      @(posedge clock) disable iff (rst)
      (killU && killF && killS && !cpuState.firmwareMode &&
       cpuState.mode == perf_counter_pkg::MODE_EXECUTIVE) |-> allowCount;
   endproperty
   a_all_kill: assert property (p_all_kill) else $error("exec off");

   property p_sticky;
      @(posedge clock) disable iff (rst)
      (pending_r[0] && !clr[0]) |=> pending_r[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("pending lost");

   property p_irq_out;
      @(posedge clock) disable iff (rst)
      ##1 (pendingIrq == pending_r);
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("irq out");

endmodule

// ---- perf_event_source.sv ----
/*
 * Behavioural model of the pipeline, cache and bus-unit event sources.
 * Assumes the bench hands it one event set and one mode for each cycle.
 */
`timescale 1ns/10ps
module perf_event_source (
   input  wire logic                           clock,
   input  wire logic                           rst,
   input  wire perf_counter_pkg::perf_events_t req,
   input  wire perf_counter_pkg::cpu_state_t   reqState,
   output perf_counter_pkg::perf_events_t      events,
   output perf_counter_pkg::cpu_state_t        cpuState
);
   // Strobes are registered, so each one follows req one cycle later and lasts as many cycles as req holds it.
   always_ff @(posedge clock)
   begin
      if (rst)
         events <= '0;
      else
         events <= req;
   end

   // firmwareMode and mode are both copied from reqState one cycle later, just as the bench sets them.
   always_ff @(posedge clock)
   begin
      if (rst)
         cpuState <= '0;
      else
         cpuState <= reqState;
   end
endmodule

// ---- tb_perf_event_counters.sv ----
/*
 * Self-checking bench for the performance event counters.
 * Assumes the counter block and the event source model are compiled first.
 */
`timescale 1ns/10ps
module tb_perf_event_counters;
   localparam logic [7:0] LO  = perf_counter_pkg::CTRL_LO_OFFSET;
   localparam logic [7:0] HI  = perf_counter_pkg::CTRL_HI_OFFSET;
   localparam logic [7:0] SUM = perf_counter_pkg::IRQ_SUMMARY_OFFSET;
   localparam logic [7:0] CLR = perf_counter_pkg::IRQ_CLEAR_OFFSET;
   localparam perf_counter_pkg::cpu_state_t USER = 3'h3;
   localparam perf_counter_pkg::cpu_state_t KERN = 3'h0;
   logic                           clock = 1'b0;
   logic                           rst = 1'b1;
   logic                           hsel = 1'b0;
   logic [7:0]                     haddr = 8'h00;
   logic [1:0]                     htrans = 2'h0;
   logic                           hwrite = 1'b0;
   logic [31:0]                    hwdata = 32'h0;
   logic [31:0]                    hrdata;
   logic                           hreadyout;
   logic                           hresp;
   logic [2:0]                     pendingIrq;
   perf_counter_pkg::perf_events_t req;
   perf_counter_pkg::perf_events_t idle;
   perf_counter_pkg::perf_events_t events;
   perf_counter_pkg::cpu_state_t   reqState;
   perf_counter_pkg::cpu_state_t   cpuState;
   logic [31:0]                    seed = 32'h711e6e0d;
   logic [31:0]                    q;
   int                             badCount = 0;
   int                             checked = 0;

   always #4 clock = ~clock;

   perf_event_counters u_perf_event_counters (
      .clock      (clock),
      .rst        (rst),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hsize      (3'h2),
      .hwdata     (hwdata),
      .hready     (hreadyout),
      .hrdata     (hrdata),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .events     (events),
      .cpuState   (cpuState),
      .pendingIrq (pendingIrq)
   );

   perf_event_source u_perf_event_source (
      .clock    (clock),
      .rst      (rst),
      .req      (req),
      .reqState (reqState),
      .events   (events),
      .cpuState (cpuState)
   );

   function automatic logic [31:0] rng();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic hit_b(logic [3:0] s, logic [3:0] sc,
                                  perf_counter_pkg::perf_events_t e);
      case (s)
         4'h0: return e.validNoIssue;
         4'h1: return e.splitIssue;
         4'h2: return e.pipeDry;
         4'h3: return e.replayTrap;
         4'h8: return sc == 4'h2 ? e.jumpRet :
                      sc == 4'h3 ? e.condBranch : e.flowChange;
         4'h9: return e.intOp;
         4'ha: return e.fpOp;
         4'hb: return e.load;
         4'hc: return e.store;
         4'hd: return e.icacheIssue;
         4'he: return e.dcacheAccess;
         4'hf: return e.busUnitEvent[0];
         default: return e.issueCount == {1'b0, s[1:0]} + 3'h1;
      endcase
   endfunction

   function automatic logic hit_c(logic [3:0] s,
                                  perf_counter_pkg::perf_events_t e);
      case (s)
         4'h0: return e.longStall;
         4'h2: return e.jumpMispredict;
         4'h3: return e.branchMispredict;
         4'h4: return e.icacheMiss;
         4'h5: return e.itlbMiss;
         4'h6: return e.dcacheLoadMiss;
         4'h7: return e.dtlbMiss;
         4'h8: return e.missFileMerge;
         4'h9: return e.loadUseReplay;
         4'ha: return e.missFileFullReplay;
         4'hc: return e.cycle;
         4'hd: return e.barrierStall;
         4'he: return e.loadLocked;
         4'hf: return e.busUnitEvent[1];
         default: return 1'b0;
      endcase
   endfunction

   // Kill bits are packed as {user, firmware, system}.
   function automatic logic live(logic [2:0] k,
                                 perf_counter_pkg::cpu_state_t st);
      if (st.firmwareMode)
         return !k[1];
      if (st.mode == perf_counter_pkg::MODE_USER)
         return !k[2];
      if (st.mode == perf_counter_pkg::MODE_KERNEL)
         return !k[0];
      return !(k[0] && !(k[2] && k[1]));
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         badCount++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic edge_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1)
      begin
         badCount++;
         report_and_stop();
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      edge_ready();
      htrans <= 2'h0;
      hwdata <= d;
      edge_ready();
      q = hrdata;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      bus(a, 1'b0, 32'h0);
      check(q, x);
      check({31'h0, hresp}, 32'h0);
   endtask

   task automatic run(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #(8 * 20000);
      badCount++;
      report_and_stop();
   end

   // ***************************************************
   // Stimulus and checks
   // ***************************************************
   // Bus cycles run in user mode on the idle set; the user kill bit freezes counting in the event-select
   // loop, and in the later loops no selected event fires, so configuring and reading add nothing to the counts.
   initial
   begin
      perf_counter_pkg::perf_events_t e;
      perf_counter_pkg::cpu_state_t   st;
      logic [3:0]  sb;
      logic [3:0]  sc;
      logic [15:0] ea;
      logic [15:0] eb;
      logic [15:0] ec;
      logic [31:0] lo;
      logic [31:0] hi;
      logic [2:0]  p;
      idle = '0;
      idle.cycle = 1'b1;
      req = idle;
      reqState = USER;
      run(6);
      rst <= 1'b0;
      rd(LO, 32'h0);
      rd(HI, 32'h0);
      rd(SUM, 32'h0);
      rd(8'h10, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         hi = rng();
         lo = rng() & 32'hffff_03ff;
         bus(HI, 1'b1, hi);
         bus(LO, 1'b1, lo);
         bus(SUM, 1'b1, rng());
         bus(8'h14, 1'b1, rng());
         rd(HI, hi);
         rd(LO, lo);
      end
      for (int j = 0; j < 18; j++)
      begin
         sb = j < 16 ? 4'(j) : 4'h8;
         sc = j < 16 ? 4'(j) : 4'(j - 14);
         lo = {sb[0], 1'b1, 14'h0, 6'h15, 2'h0, sb, sc};
         ea = 16'h0;
         eb = 16'h0;
         ec = 16'h0;
         bus(HI, 1'b1, 32'h0);
         bus(LO, 1'b1, lo);
         for (int c = 0; c < 12; c++)
         begin
            hi = rng();
            e = hi;
            e.cycle = 1'b1;
            e.issueCount = 3'(rng() % 5);
            ea += 16'(e.issueCount != 3'h0 || !sb[0]);
            eb += 16'(hit_b(sb, sc, e));
            ec += 16'(hit_c(sc, e));
            req <= e;
            reqState <= KERN;
            @(posedge clock);
         end
         req <= idle;
         reqState <= USER;
         run(2);
         rd(HI, {ea, eb});
         rd(LO, {lo[31:30], ec[13:0], lo[15:0]});
      end
      for (int k = 0; k < 8; k++)
         for (int m = 0; m < 5; m++)
         begin
            st = m == 4 ? {1'b1, 2'(rng())} : {1'b0, 2'(m)};
            lo = {1'b1, 1'(k >> 2), 14'h0, 6'h15, 1'(k >> 1), 1'(k), 8'h40};
            bus(HI, 1'b1, 32'h0);
            bus(LO, 1'b1, lo);
            e = idle;
            e.issueCount = 3'h1;
            e.longStall = 1'b1;
            req <= e;
            reqState <= st;
            run(5);
            req <= idle;
            reqState <= USER;
            run(2);
            ea = live(3'(k), st) ? 16'h5 : 16'h0;
            rd(HI, {ea, ea});
            rd(LO, {lo[31:30], ea[13:0], lo[15:0]});
         end
      for (int c = 1; c < 4; c++)
      begin
         ea = c == 3 ? 16'h00ff : 16'hffff;
         ec = c == 3 ? 16'h00ff : 16'h3fff;
         p = c > 1 ? 3'h7 : 3'h0;
         bus(HI, 1'b1, {ea, ea});
         bus(LO, 1'b1, {2'h2, ec[13:0], {3{2'(c)}}, 10'h40});
         req <= e;
         @(posedge clock);
         req <= idle;
         run(3);
         ea = c == 3 ? 16'h0100 : 16'h0000;
         check({29'h0, pendingIrq}, {29'h0, p});
         rd(SUM, {2'h0, p, 27'h0});
         rd(HI, {ea, ea});
         rd(LO, {2'h2, ea[13:0], {3{2'(c)}}, 10'h40});
         bus(CLR, 1'b1, 32'h1000_0000);
         run(1);
         check({29'h0, pendingIrq}, {29'h0, p & 3'h5});
         bus(CLR, 1'b1, 32'h3800_0000);
         run(1);
         check({29'h0, pendingIrq}, 32'h0);
      end
      report_and_stop();
   end
endmodule
